// ===== pkg/ulpd_pkg.sv
// constants and carrier types for the low-power divisor block
package ulpd_pkg;
   // register byte addresses
   localparam logic [31:0] ADDR_DIV_LOW    = 32'h5000_1120; // low_power_divisor_low_byte
   localparam logic [31:0] ADDR_DIV_HIGH   = 32'h5000_1124; // low_power_divisor_high_byte
   localparam logic [31:0] ADDR_LP_CTRL    = 32'h5000_11f0; // infrared mode select
   localparam logic [31:0] ADDR_LP_STATUS  = 32'h5000_11f4; // block status, read only
   // field positions
   localparam int unsigned LATCH_BIT_POS   = 7;  // divisor_latch_access_bit in line control
   localparam int unsigned CTRL_IR_POS     = 0;  // ir mode enable in control register
   localparam int unsigned ST_RUN_POS      = 0;  // baud clock running
   localparam int unsigned ST_SETTLE_POS   = 1;  // divisor settle window still open
   localparam int unsigned ST_PULSE_POS    = 2;  // qualified infrared pulse present
   localparam int unsigned ST_LATCH_POS    = 3;  // latch access bit as seen
   // reset values
   localparam logic [7:0]  DIV_BYTE_RST    = 8'h00;
   localparam logic        IR_MODE_RST     = 1'b0;
   // timing
   localparam int unsigned SCLK_MHZ        = 250;  // serial clock rate
   localparam int unsigned OVERSAMPLE      = 16;   // baud clock is sclk / (16 * divisor)
   localparam int unsigned SETTLE_CYCLES   = 8;    // settle time after a divisor write
   localparam logic [3:0]  SETTLE_LOAD     = 4'(SETTLE_CYCLES);
   localparam logic [3:0]  SUB_LAST        = 4'(OVERSAMPLE - 1);

   // register port request from software
   typedef struct packed {
      logic [31:0] addr;   // byte address
      logic [31:0] wdata;  // write data, low byte used
      logic        wr;     // one-cycle write strobe
      logic        rd;     // one-cycle read strobe
   } ulpd_bus_req_s;
endpackage

// ===== logic/ulpd_pulse_det.sv
// minimum-width infrared pulse qualifier
`timescale 1ns/1ns
module ulpd_pulse_det (
   input  wire logic clock,       // serial clock
   input  wire logic reset_n,     // async reset, active low
   input  wire logic enable,      // divisor nonzero
   input  wire logic x16_tick,    // low-power oversample enable
   input  wire logic sir_in,      // raw infrared input, pulse high
   output logic      pulse_valid  // high while a qualified pulse lasts
);
   import ulpd_pkg::*;

   // whole state of the qualifier
   typedef struct packed {
      logic valid;   // pulse has spanned at least one oversample tick
   } ulpd_det_s;

   ulpd_det_s st_ff;   // registered state
   ulpd_det_s nxt_st;  // next state

   // a pulse only counts once it covers a tick; narrower glitches are dropped
   always_comb begin
      nxt_st = st_ff;
      if (!enable || !sir_in) begin
         nxt_st.valid = 1'b0;  // no detection at all with a zero divisor, see R5
      end else if (x16_tick) begin
         nxt_st.valid = 1'b1;
      end
   end

   // state register
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pulse_valid = st_ff.valid;

   chk_zero_no_pulse: assert property (@(posedge clock) disable iff (!reset_n) // see R5
      !enable |=> !pulse_valid) else $error("pulse qualified with divisor zero");
   chk_narrow_reject: assert property (@(posedge clock) disable iff (!reset_n) // see R7
      $rose(pulse_valid) |-> $past(x16_tick) && $past(sir_in))
      else $error("pulse qualified without a covering tick");
endmodule

// ===== logic/ulpd_top.sv
// low-power divisor latch, baud clock and infrared receive selection
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns

// Summary of operation
// R1: 16-bit divisor from two read/write bytes
// R2: divisor bytes reachable only with latch bit set
// R3: baud clock equals sclk over sixteen times divisor
// R4: software picks divisor for 115.2K baud
// R5: zero divisor stops clock and pulse detection
// R6: software waits eight slow cycles after writes
// R7: infrared mode receives from infrared input line
// R8: divisor bytes reset to zero
module ulpd_top (
   input  wire logic                   clock,                  // serial clock, 250 MHz
   input  wire logic                   reset_n,                // async reset, active low
   input  wire ulpd_pkg::ulpd_bus_req_s bus_req,               // register port request
   output logic [31:0]                 rd_data,                // read data, cycle after strobe
   input  wire logic [7:0]             line_control_register,  // owned by the uart core
   input  wire logic                   serial_in,              // ordinary serial input
   input  wire logic                   sir_in,                 // infrared input, pulse high
   output logic                        lp_baud_x16,            // oversample enable pulse
   output logic                        lp_baud_tick,           // low-power baud enable pulse
   output logic                        rx_line,                // line seen by the receiver
   output logic                        settle_busy             // divisor settle window open
);
   import ulpd_pkg::*;

   // whole state of the block
   typedef struct packed {
      logic [7:0]  div_low;     // divisor bits 7:0
      logic [7:0]  div_high;    // divisor bits 15:8
      logic        ir_mode;     // infrared receive mode
      logic [15:0] div_cnt;     // sclk counter within one oversample period
      logic [3:0]  sub_cnt;     // oversample counter within one baud period
      logic        x16_tick;    // oversample pulse
      logic        baud_tick;   // baud pulse
      logic [3:0]  settle_cnt;  // cycles left in settle window
      logic        settle;      // settle window open, registered for the port
      logic [31:0] rd_data;     // read answer
      logic        rx_line;     // selected receive line
   } ulpd_state_s;

   ulpd_state_s st_ff;   // registered state
   ulpd_state_s nxt_st;  // next state

   logic        latch_open;  // divisor latch access bit
   logic [15:0] divisor;     // full divisor
   logic        div_nz;      // divisor nonzero, clock running
   logic        pulse_valid; // qualified infrared pulse
   logic        hit_low;     // address decodes
   logic        hit_high;
   logic        hit_ctrl;
   logic        hit_stat;

   assign latch_open = line_control_register[LATCH_BIT_POS];
   assign divisor  = {st_ff.div_high, st_ff.div_low};   // see R1
   assign div_nz   = (divisor != 16'h0000);
   assign hit_low  = (bus_req.addr == ADDR_DIV_LOW);
   assign hit_high = (bus_req.addr == ADDR_DIV_HIGH);
   assign hit_ctrl = (bus_req.addr == ADDR_LP_CTRL);
   assign hit_stat = (bus_req.addr == ADDR_LP_STATUS);

   // pulse qualifier runs on the low-power oversample tick
   ulpd_pulse_det u_det (
      .clock       (clock),
      .reset_n     (reset_n),
      .enable      (div_nz),
      .x16_tick    (st_ff.x16_tick),
      .sir_in      (sir_in),
      .pulse_valid (pulse_valid)
   );

   // next-state logic: register port, divider, receive select
   always_comb begin
      nxt_st         = st_ff;
      nxt_st.rd_data = 32'h0000_0000;  // unmapped or gated reads answer zero
      // writes; divisor bytes ignored while the latch bit is clear
      if (bus_req.wr) begin
         if (hit_low && latch_open) begin                  // see R2
            nxt_st.div_low    = bus_req.wdata[7:0];       // see R1
            nxt_st.settle_cnt = SETTLE_LOAD;
         end
         if (hit_high && latch_open) begin                 // see R2
            nxt_st.div_high   = bus_req.wdata[7:0];       // see R1
            nxt_st.settle_cnt = SETTLE_LOAD;
         end
         if (hit_ctrl) begin
            nxt_st.ir_mode = bus_req.wdata[CTRL_IR_POS];
         end
      end else if (st_ff.settle_cnt != 4'h0) begin
         nxt_st.settle_cnt = st_ff.settle_cnt - 4'h1;
      end
      // settle flag kept in a flop so the port carries no decode glitch
      nxt_st.settle = (nxt_st.settle_cnt != 4'h0);
      // reads; upper bits of the byte registers stay zero
      if (bus_req.rd) begin
         if (hit_low && latch_open) begin                  // see R2
            nxt_st.rd_data[7:0] = st_ff.div_low;           // see R1
         end else if (hit_high && latch_open) begin        // see R2
            nxt_st.rd_data[7:0] = st_ff.div_high;          // see R1
         end else if (hit_ctrl) begin
            nxt_st.rd_data[CTRL_IR_POS] = st_ff.ir_mode;
         end else if (hit_stat) begin
            nxt_st.rd_data[ST_RUN_POS]    = div_nz;
            nxt_st.rd_data[ST_SETTLE_POS] = (st_ff.settle_cnt != 4'h0);
            nxt_st.rd_data[ST_PULSE_POS]  = pulse_valid;
            nxt_st.rd_data[ST_LATCH_POS]  = latch_open;
         end
      end
      // divider: period of x16 is divisor cycles, baud is sixteen of those
      nxt_st.x16_tick  = 1'b0;
      nxt_st.baud_tick = 1'b0;
      if (!div_nz || (bus_req.wr && latch_open && (hit_low || hit_high))) begin
         // zero divisor holds the clock; a new divisor restarts it cleanly
         nxt_st.div_cnt = 16'h0000;                        // see R5
         nxt_st.sub_cnt = 4'h0;
      end else if (st_ff.div_cnt >= divisor - 16'h0001) begin
         nxt_st.div_cnt  = 16'h0000;                       // see R3
         nxt_st.x16_tick = 1'b1;
         nxt_st.sub_cnt  = st_ff.sub_cnt + 4'h1;
         if (st_ff.sub_cnt == SUB_LAST) begin
            nxt_st.baud_tick = 1'b1;                       // see R3
         end
      end else begin
         nxt_st.div_cnt = st_ff.div_cnt + 16'h0001;
      end
      // infrared mode takes the qualified pulse line; a pulse means a zero bit
      nxt_st.rx_line = st_ff.ir_mode ? ~pulse_valid : serial_in;   // see R7
   end

   // state register; divisor bytes come up zero so nothing runs
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st_ff          <= '0;
         st_ff.div_low  <= DIV_BYTE_RST;                   // see R8
         st_ff.div_high <= DIV_BYTE_RST;                   // see R8
         st_ff.ir_mode  <= IR_MODE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rd_data      = st_ff.rd_data;
   assign lp_baud_x16  = st_ff.x16_tick;
   assign lp_baud_tick = st_ff.baud_tick;
   assign rx_line      = st_ff.rx_line;
   assign settle_busy  = st_ff.settle;

   // helper: cycles since last baud tick, cleared on any divisor change
   logic [20:0] gap_ff;      // cycle counter between baud ticks
   logic        gap_ok_ff;   // counter spans an undisturbed period
   logic        touched_ff;  // any divisor write since reset
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         gap_ff     <= 21'h0;
         gap_ok_ff  <= 1'b0;
         touched_ff <= 1'b0;
      end else begin
         if (bus_req.wr && latch_open && (hit_low || hit_high)) begin
            touched_ff <= 1'b1;
            gap_ok_ff  <= 1'b0;
            gap_ff     <= 21'h0;
         end else if (st_ff.baud_tick) begin
            gap_ok_ff <= 1'b1;
            gap_ff    <= 21'h1;
         end else begin
            gap_ff <= gap_ff + 21'h1;
         end
      end
   end

   chk_div_read_back: assert property (@(posedge clock) disable iff (!reset_n) // see R1
      bus_req.rd && latch_open && hit_high |=> rd_data == {24'h0, $past(st_ff.div_high)})
      else $error("high divisor byte read back wrong");
   chk_gate_write: assert property (@(posedge clock) disable iff (!reset_n) // see R2
      bus_req.wr && !latch_open && (hit_low || hit_high) |=> $stable(divisor))
      else $error("divisor written with latch bit clear");
   chk_gate_read: assert property (@(posedge clock) disable iff (!reset_n) // see R2
      bus_req.rd && !latch_open && (hit_low || hit_high) |=> rd_data == 32'h0)
      else $error("divisor read with latch bit clear");
   chk_baud_period: assert property (@(posedge clock) disable iff (!reset_n) // see R3
      st_ff.baud_tick && gap_ok_ff |-> gap_ff == {1'b0, divisor, 4'h0})
      else $error("baud period not sixteen times divisor");
   chk_zero_stop: assert property (@(posedge clock) disable iff (!reset_n) // see R5
      !div_nz ##1 !div_nz |-> !lp_baud_x16 && !lp_baud_tick)
      else $error("baud clock runs with zero divisor");
   chk_ir_select: assert property (@(posedge clock) disable iff (!reset_n) // see R7
      st_ff.ir_mode |=> rx_line == !$past(pulse_valid))
      else $error("infrared mode not taking infrared line");
   chk_reset_zero: assert property (@(posedge clock) disable iff (!reset_n) // see R8
      !touched_ff |-> divisor == 16'h0000)
      else $error("divisor not zero before first write");

   cov_div_one_tick: cover property (@(posedge clock) disable iff (!reset_n)
      divisor == 16'h0001 && lp_baud_tick);
   cov_ir_pulse: cover property (@(posedge clock) disable iff (!reset_n)
      st_ff.ir_mode && $fell(rx_line));
   cov_gated_write: cover property (@(posedge clock) disable iff (!reset_n)
      bus_req.wr && !latch_open && hit_low);
endmodule

// ===== dv/ulpd_ir_xcvr.sv
// infrared transceiver model that lights the receive line
`timescale 1ns/1ns
module ulpd_ir_xcvr (
   input  wire logic       clock,   // serial clock
   input  wire logic       reset_n, // async reset, active low
   input  wire logic       fire,    // start one light pulse
   input  wire logic [7:0] len,     // pulse length in cycles
   output logic            sir_in   // high while lit
);
   logic [7:0] left_ff; // cycles of light remaining
   // photodiode rests dark, so the line idles low between pulses
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         left_ff <= 8'h00;
      end else if (fire) begin
         left_ff <= len;
      end else if (left_ff != 8'h00) begin
         left_ff <= left_ff - 8'h01;
      end
   end
   assign sir_in = (left_ff != 8'h00);
endmodule

// ===== dv/uart_sir_low_power_divisor_bench.sv
// self-checking bench for the low-power divisor block
`timescale 1ns/1ns
module uart_sir_low_power_divisor_bench;
   import ulpd_pkg::*;
   typedef struct packed {
      logic [7:0]  line_ctl; // latch bit setting during the access
      logic [31:0] addr;  // register address
      logic [31:0] wdata; // value written
      logic        wr_en; // write before reading back
      logic [31:0] exp;   // expected read value
   } ulpd_row_s;
   logic          clock, reset_n, serial_in, sir_in, fire;
   logic          lp_baud_x16, lp_baud_tick, rx_line, settle_busy;
   logic [7:0]    line_control_register, len;
   logic [31:0]   rd_data, q;
   ulpd_bus_req_s bus_req;
   int            failures, checked;
   logic [31:0]   nx, nt, nl; // four-state so an unknown output cannot pass
   // ordinary register cases; bytes beyond 7:0 must read back as zero
   // the control register answers whatever the latch bit says
   ulpd_row_s rows [7] = '{
      '{8'h80, ADDR_DIV_LOW, 32'ha5, 1'b1, 32'ha5},
      '{8'h80, ADDR_DIV_HIGH, 32'h3c, 1'b1, 32'h3c},
      '{8'h00, ADDR_DIV_LOW, 32'h11, 1'b1, 32'h00},
      '{8'h80, ADDR_DIV_LOW, 32'h00, 1'b0, 32'ha5},
      '{8'h80, ADDR_DIV_HIGH, 32'hffff_ff77, 1'b1, 32'h77},
      '{8'h00, ADDR_LP_CTRL, 32'h1, 1'b1, 32'h1},
      '{8'h80, 32'h5000_1128, 32'h55, 1'b1, 32'h00}};
   // last divisor gives 115.2K at the 250 MHz serial clock
   logic [15:0] divs [3] = '{16'h0001, 16'h0003, 16'h0088};
   ulpd_top u_dut (.clock(clock), .reset_n(reset_n), .bus_req(bus_req), .rd_data(rd_data),
      .line_control_register(line_control_register), .serial_in(serial_in),
      .sir_in(sir_in), .lp_baud_x16(lp_baud_x16), .lp_baud_tick(lp_baud_tick),
      .rx_line(rx_line), .settle_busy(settle_busy));
   ulpd_ir_xcvr u_ir (.clock(clock), .reset_n(reset_n), .fire(fire), .len(len),
      .sir_in(sir_in));
   // 250 MHz serial clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'b1;
      @(posedge clock);
      bus_req.wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [31:0] a);
      @(posedge clock);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge clock);
      bus_req.rd <= 1'b0;
      #1 q = rd_data;
   endtask
   // counts pulses and receiver low cycles over n settled samples
   task automatic count(input int n);
      nx = 0;
      nt = 0;
      nl = 0;
      repeat (n) begin
         @(posedge clock);
         #1;
         nx += lp_baud_x16;
         nt += lp_baud_tick;
         nl += !rx_line;
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // watchdog: the sequence needs about 10k cycles
   initial begin
      #160000;
      failures++;
      give_verdict();
   end
   initial begin
      bus_req = '0;
      line_control_register = 8'h80;
      serial_in = 1'b1;
      fire = 1'b0;
      len = 8'd20;
      reset_n = 1'b0;
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      rd(ADDR_DIV_LOW);
      chk_word("low byte reset", 32'h0, q);
      rd(ADDR_DIV_HIGH);
      chk_word("high byte reset", 32'h0, q);
      count(40);
      chk_word("x16 after reset", 32'd0, nx);
      foreach (rows[i]) begin
         @(posedge clock);
         line_control_register <= rows[i].line_ctl;
         if (rows[i].wr_en) begin
            wr(rows[i].addr, rows[i].wdata);
         end
         rd(rows[i].addr);
         chk_word("register row", rows[i].exp, q);
      end
      @(posedge clock);
      #1 chk_word("read data after", 32'h0, rd_data);
      // baud rate over four whole baud periods, phase independent
      foreach (divs[i]) begin
         wr(ADDR_DIV_HIGH, {24'h0, divs[i][15:8]});
         wr(ADDR_DIV_LOW, {24'h0, divs[i][7:0]});
         #1 chk_word("settle open", 32'h1, {31'h0, settle_busy});
         count(64 * divs[i]);
         chk_word("x16 pulses", 32'd64, nx);
         chk_word("baud ticks", 32'd4, nt);
      end
      // running, settle closed, no light, latch bit set
      rd(ADDR_LP_STATUS);
      chk_word("status word", 32'h9, q);
      // zero divisor: clock stops and the qualifier ignores light
      wr(ADDR_DIV_LOW, 32'h0);
      wr(ADDR_LP_CTRL, 32'h1);
      serial_in <= 1'b0;
      fire <= 1'b1;
      @(posedge clock);
      fire <= 1'b0;
      count(40);
      chk_word("x16 while zero", 32'd0, nx);
      chk_word("ir lows while zero", 32'd0, nl);
      wr(ADDR_DIV_LOW, 32'h1);
      repeat (7) @(posedge clock);
      #1 chk_word("settle late", 32'h1, {31'h0, settle_busy});
      @(posedge clock);
      #1 chk_word("settle closed", 32'h0, {31'h0, settle_busy});
      @(posedge clock);
      fire <= 1'b1;
      @(posedge clock);
      fire <= 1'b0;
      count(40);
      // light of 20 cycles, minus qualifier latency; serial_in low is ignored
      chk_word("ir low span", 32'h1, {31'h0, nl >= 16 && nl <= 20});
      wr(ADDR_LP_CTRL, 32'h0);
      repeat (2) begin
         @(posedge clock);
         serial_in <= !serial_in;
         @(posedge clock);
         #1 chk_word("serial follow", {31'h0, serial_in}, {31'h0, rx_line});
      end
      // reset in mid-run brings a running divisor back to zero
      @(posedge clock);
      reset_n <= 1'b0;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      rd(ADDR_DIV_LOW);
      chk_word("low byte rerun", 32'h0, q);
      count(20);
      chk_word("x16 after rerun", 32'd0, nx);
      give_verdict();
   end
endmodule
